// File: verilog/fmpm_config_top.sv
// Float-mode configuration registers, slot B LED pulse timer and sample math
`timescale 1ns/1ps
`default_nettype none
module fmpm_config_top
    import fmpm_pkg::*;
#(
    parameter int SAMPLE_W = 14,
    parameter int ACC_W = 27,
    parameter int PULSE_CNT_W = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Host register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Mode inputs
    input wire logic i_slot_a_float_on,
    input wire logic [1:0] i_slot_b_float_enable,
    input wire logic i_transimpedance_amp_mode,
    output logic o_integrator_as_buffer,
    // Slot B float LED pulse sequence
    input wire logic i_slot_b_seq_start,
    input wire logic [PULSE_CNT_W-1:0] i_slot_b_pulse_count,
    output logic [2:0] o_led_drive,
    output logic o_slot_b_seq_busy,
    // Sample stream from the converter
    input wire logic i_sample_valid,
    input wire logic i_sample_slot,
    input wire logic i_sample_first,
    input wire logic i_sample_last,
    input wire logic [SAMPLE_W-1:0] i_sample,
    // Accumulated slot result
    output logic o_result_valid,
    output logic o_result_slot,
    output logic [ACC_W-1:0] o_result
);

    // Elaboration-time checks
    if (ACC_W < SAMPLE_W + 2) begin : g_bad_acc
        $error("ACC_W must exceed SAMPLE_W by at least two bits");
    end
    if (PULSE_CNT_W < 1 || PULSE_CNT_W > 16) begin : g_bad_cnt
        $error("PULSE_CNT_W must be 1 to 16");
    end

    // Configuration fields
    logic [1:0] slot_b_float_led_choice;
    logic [4:0] slot_b_float_pulse_width;
    logic [7:0] float_first_pulse_delay;
    logic [1:0] slot_b_pair_two_combine;
    logic [1:0] slot_a_pair_two_combine;
    logic integrator_buffer_enable;
    logic [1:0] slot_b_pair_one_combine;
    logic [1:0] slot_a_pair_one_combine;

    // Register decode
    wire hit_led = (i_reg_addr == REG_LED_PULSE_ADDR);
    wire hit_math = (i_reg_addr == REG_MATH_ADDR);
    wire wr_led = i_reg_wr & hit_led;
    wire wr_math = i_reg_wr & hit_math;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            slot_b_float_led_choice <= LED_CHOICE_RST;
            slot_b_float_pulse_width <= PULSE_WIDTH_RST;
            float_first_pulse_delay <= FIRST_DELAY_RST;
        end else if (wr_led) begin
            slot_b_float_led_choice <= i_reg_wdata[LED_CHOICE_LSB +: 2];
            slot_b_float_pulse_width <= i_reg_wdata[PULSE_WIDTH_LSB +: 5];
            float_first_pulse_delay <= i_reg_wdata[FIRST_DELAY_LSB +: 8];
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            slot_b_pair_two_combine <= COMBINE_RST;
            slot_a_pair_two_combine <= COMBINE_RST;
            integrator_buffer_enable <= BUFFER_EN_RST;
            slot_b_pair_one_combine <= COMBINE_RST;
            slot_a_pair_one_combine <= COMBINE_RST;
        end else if (wr_math) begin
            slot_b_pair_two_combine <= i_reg_wdata[B_PAIR_TWO_LSB +: 2];
            slot_a_pair_two_combine <= i_reg_wdata[A_PAIR_TWO_LSB +: 2];
            integrator_buffer_enable <= i_reg_wdata[BUFFER_EN_BIT];
            slot_b_pair_one_combine <= i_reg_wdata[B_PAIR_ONE_LSB +: 2];
            slot_a_pair_one_combine <= i_reg_wdata[A_PAIR_ONE_LSB +: 2];
        end
    end

    // Read-back images; reserved bits read as zero
    logic [15:0] led_image;
    logic [15:0] math_image;
    always_comb begin
        led_image = 16'h0000;
        led_image[LED_CHOICE_LSB +: 2] = slot_b_float_led_choice;
        led_image[PULSE_WIDTH_LSB +: 5] = slot_b_float_pulse_width;
        led_image[FIRST_DELAY_LSB +: 8] = float_first_pulse_delay;
        math_image = 16'h0000;
        math_image[B_PAIR_TWO_LSB +: 2] = slot_b_pair_two_combine;
        math_image[A_PAIR_TWO_LSB +: 2] = slot_a_pair_two_combine;
        math_image[BUFFER_EN_BIT] = integrator_buffer_enable;
        math_image[B_PAIR_ONE_LSB +: 2] = slot_b_pair_one_combine;
        math_image[A_PAIR_ONE_LSB +: 2] = slot_a_pair_one_combine;
    end

    wire [15:0] read_mux = hit_led ? led_image :
                           hit_math ? math_image : UNMAPPED_READ;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reg_rdata <= 16'h0000;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= read_mux;
            end
        end
    end

    // Integrator as buffer only in transimpedance mode
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_integrator_as_buffer <= 1'b0;
        end else begin
            o_integrator_as_buffer <= integrator_buffer_enable & i_transimpedance_amp_mode;
        end
    end

    // Slot B float mode gate
    wire slot_b_float_on = (i_slot_b_float_enable == FLOAT_ON_CODE);

    // Slot B pulse timer
    fmpm_pulse_state_t state;
    fmpm_pulse_state_t next_state;
    logic [STEP_CNT_W-1:0] step_cnt;
    logic [7:0] steps_left;
    logic [7:0] next_steps_left;
    logic [PULSE_CNT_W-1:0] pulses_left;
    logic [PULSE_CNT_W-1:0] next_pulses_left;
    logic [1:0] run_choice;
    logic [4:0] run_width;

    wire step_tick = (state != PS_IDLE) && (step_cnt == STEP_LAST);
    wire start_ok = i_slot_b_seq_start && slot_b_float_on &&
                    (i_slot_b_pulse_count != '0);
    wire phase_done = step_tick && (steps_left <= 8'h01);
    wire last_pulse = (pulses_left == PULSE_CNT_W'(1));

    // Driver select: 0 none, 1..3 first to third driver
    wire [2:0] led_onehot = {run_choice == 2'h3, run_choice == 2'h2,
                             run_choice == 2'h1};

    always_comb begin
        next_state = state;
        next_steps_left = steps_left;
        next_pulses_left = pulses_left;
        if (state != PS_IDLE && !slot_b_float_on) begin
            next_state = PS_IDLE;
        end else begin
            unique case (state)
                PS_IDLE: begin
                    if (start_ok) begin
                        next_state = PS_DELAY;
                        next_steps_left = float_first_pulse_delay;
                        next_pulses_left = i_slot_b_pulse_count;
                    end
                end
                PS_DELAY, PS_GAP: begin
                    if (phase_done) begin
                        next_state = PS_PULSE;
                        next_steps_left = {3'h0, run_width};
                    end else if (step_tick) begin
                        next_steps_left = steps_left - 8'h01;
                    end
                end
                PS_PULSE: begin
                    if (phase_done) begin
                        next_pulses_left = pulses_left - PULSE_CNT_W'(1);
                        next_steps_left = GAP_STEPS;
                        next_state = last_pulse ? PS_IDLE : PS_GAP;
                    end else if (step_tick) begin
                        next_steps_left = steps_left - 8'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= PS_IDLE;
            steps_left <= 8'h00;
            pulses_left <= '0;
        end else begin
            state <= next_state;
            steps_left <= next_steps_left;
            pulses_left <= next_pulses_left;
        end
    end

    // 1 us step divider, restarted with each sequence
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            step_cnt <= '0;
        end else if (state == PS_IDLE || step_tick) begin
            step_cnt <= '0;
        end else begin
            step_cnt <= step_cnt + STEP_CNT_W'(1);
        end
    end

    // Settings are frozen for the length of a sequence
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            run_choice <= LED_CHOICE_RST;
            run_width <= PULSE_WIDTH_RST;
        end else if (state == PS_IDLE && start_ok) begin
            run_choice <= slot_b_float_led_choice;
            run_width <= slot_b_float_pulse_width;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_led_drive <= 3'h0;
            o_slot_b_seq_busy <= 1'b0;
        end else begin
            o_led_drive <= (next_state == PS_PULSE) ? led_onehot : 3'h0;
            o_slot_b_seq_busy <= (next_state != PS_IDLE);
        end
    end

    // Sample accumulators, slot A at index 0 and slot B at index 1
    logic [ACC_W-1:0] slot_next_acc [2];
    wire [1:0] float_on_vec = {slot_b_float_on, i_slot_a_float_on};
    wire [3:0] pair_one_vec = {slot_b_pair_one_combine, slot_a_pair_one_combine};
    wire [3:0] pair_two_vec = {slot_b_pair_two_combine, slot_a_pair_two_combine};

    for (genvar s = 0; s < 2; s++) begin : g_slot
        fmpm_slot_accum #(
            .SAMPLE_W(SAMPLE_W),
            .ACC_W(ACC_W)
        ) u_accum (
            .i_clk(i_clk),
            .i_rstn(i_rstn),
            .i_valid(i_sample_valid && (i_sample_slot == 1'(s))),
            .i_first(i_sample_first),
            .i_sample(i_sample),
            .i_float_on(float_on_vec[s]),
            .i_pair_one(pair_one_vec[2*s +: 2]),
            .i_pair_two(pair_two_vec[2*s +: 2]),
            .o_next_acc(slot_next_acc[s])
        );
    end

    wire report = i_sample_valid & i_sample_last;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_result_valid <= 1'b0;
            o_result_slot <= 1'b0;
            o_result <= '0;
        end else begin
            o_result_valid <= report;
            if (report) begin
                o_result_slot <= i_sample_slot;
                o_result <= slot_next_acc[i_sample_slot];
            end
        end
    end

endmodule // fmpm_config_top
`default_nettype wire

// File: verilog/fmpm_pkg.sv
// Constants, field layout and state type for the float-mode pulse and sample math block
// Notes on behaviour
// - Slot B LED choice: 0 no LED, 1..3 pick first, second, third driver.
// - Slot B float LED pulse lasts width field times 1 us; width resets to 3.
// - Eight-bit delay before first float pulse, reset 0x20, held in slot B register.
// - Slot B bits 11:10 and slot A bits 9:8 combine third and fourth samples.
// - Third/fourth codes: 00 add both, 01 subtract fourth, 10 subtract third, 11 both.
// - Third/fourth combining repeats in every group of four samples.
// - Bits 6:5 combine first and second samples of each slot B group.
// - First/second codes: 00 add both, 01 subtract second, 10 subtract first, 11 both.
// - First/second combining repeats in every group of four samples.
// - Bit 7 set makes the integrator a buffer in transimpedance mode; resets 0.
// - Slot B float behaviour only when its float enable equals 3.
package fmpm_pkg;

    // Register addresses as seen on the host port
    localparam logic [7:0] REG_LED_PULSE_ADDR = 8'h3F;
    localparam logic [7:0] REG_MATH_ADDR = 8'h58;

    // Field positions
    localparam int LED_CHOICE_LSB = 14;
    localparam int PULSE_WIDTH_LSB = 8;
    localparam int FIRST_DELAY_LSB = 0;
    localparam int B_PAIR_TWO_LSB = 10;
    localparam int A_PAIR_TWO_LSB = 8;
    localparam int BUFFER_EN_BIT = 7;
    localparam int B_PAIR_ONE_LSB = 5;
    localparam int A_PAIR_ONE_LSB = 1;

    // Values after reset
    localparam logic [1:0] LED_CHOICE_RST = 2'h0;
    localparam logic [4:0] PULSE_WIDTH_RST = 5'h03;
    localparam logic [7:0] FIRST_DELAY_RST = 8'h20;
    localparam logic [1:0] COMBINE_RST = 2'h0;
    localparam logic BUFFER_EN_RST = 1'b0;
    localparam logic [15:0] UNMAPPED_READ = 16'h0000;

    // Float enable code that turns float mode on
    localparam logic [1:0] FLOAT_ON_CODE = 2'h3;

    // Timing: one step of the pulse timer is 1 us
    localparam int CLK_MHZ = 250;
    localparam int STEP_US = 1;
    localparam int STEP_CYCLES = CLK_MHZ * STEP_US;
    localparam int STEP_CNT_W = $clog2(STEP_CYCLES);
    localparam logic [STEP_CNT_W-1:0] STEP_LAST = STEP_CNT_W'(STEP_CYCLES - 1);
    localparam logic [7:0] GAP_STEPS = 8'h01;

    typedef enum logic [1:0] {
        PS_IDLE,
        PS_DELAY,
        PS_PULSE,
        PS_GAP
    } fmpm_pulse_state_t;

endpackage

// File: verilog/fmpm_slot_accum.sv
// Per-slot sample accumulator with four-pulse add/subtract pattern
`timescale 1ns/1ps
`default_nettype none
module fmpm_slot_accum
    import fmpm_pkg::*;
#(
    parameter int SAMPLE_W = 14,
    parameter int ACC_W = 27
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Sample stream
    input wire logic i_valid,
    input wire logic i_first,
    input wire logic [SAMPLE_W-1:0] i_sample,
    // Combine settings
    input wire logic i_float_on,
    input wire logic [1:0] i_pair_one,
    input wire logic [1:0] i_pair_two,
    // Accumulator value including the current sample
    output logic [ACC_W-1:0] o_next_acc
);
    logic [1:0] pos;
    logic [ACC_W-1:0] acc;

    wire [1:0] eff_pos = i_first ? 2'h0 : pos;
    // Position 0..3 inside the group picks its sign bit; pattern repeats per four
    wire sub_sel = (eff_pos == 2'h0) ? i_pair_one[1] :
                   (eff_pos == 2'h1) ? i_pair_one[0] :
                   (eff_pos == 2'h2) ? i_pair_two[1] :
                   i_pair_two[0];
    wire subtract = i_float_on & sub_sel;
    wire [ACC_W-1:0] ext = {{(ACC_W-SAMPLE_W){1'b0}}, i_sample};
    wire [ACC_W-1:0] term = subtract ? (ACC_W'(0) - ext) : ext;
    wire [ACC_W-1:0] base = i_first ? ACC_W'(0) : acc;

    assign o_next_acc = base + term;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pos <= 2'h0;
            acc <= '0;
        end else if (i_valid) begin
            pos <= eff_pos + 2'h1;
            acc <= o_next_acc;
        end
    end
endmodule // fmpm_slot_accum
`default_nettype wire

// File: dv/fmpm_config_props.sv
// Port-level assertions for the float-mode configuration block
`timescale 1ns/1ps
`default_nettype none
module fmpm_config_props
    import fmpm_pkg::*;
#(
    parameter int PULSE_CNT_W = 8
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [15:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic i_transimpedance_amp_mode,
    input wire logic o_integrator_as_buffer,
    input wire logic [1:0] i_slot_b_float_enable,
    input wire logic i_slot_b_seq_start,
    input wire logic [PULSE_CNT_W-1:0] i_slot_b_pulse_count,
    input wire logic [2:0] o_led_drive,
    input wire logic o_slot_b_seq_busy,
    input wire logic i_sample_valid,
    input wire logic i_sample_slot,
    input wire logic i_sample_last,
    input wire logic o_result_valid,
    input wire logic o_result_slot
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    wire unmapped = i_reg_addr != REG_LED_PULSE_ADDR && i_reg_addr != REG_MATH_ADDR;
    sequence seq_taken;
        i_slot_b_seq_start && !o_slot_b_seq_busy
            && i_slot_b_float_enable == FLOAT_ON_CODE && i_slot_b_pulse_count != 0;
    endsequence
    sequence seq_dark_delay;
        (o_slot_b_seq_busy && o_led_drive == 3'h0) [*8];
    endsequence
    a_start_then_delay: assert property (seq_taken |=> seq_dark_delay)
        else $error("sequence start not followed by dark delay");
    a_rvalid_after_rd: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read not answered");
    a_unmapped_reads_zero: assert property (i_reg_rd && unmapped |=> o_reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_buffer_needs_tia: assert property (!$past(i_transimpedance_amp_mode)
        |-> !o_integrator_as_buffer)
        else $error("buffer on outside transimpedance mode");
    a_led_onehot: assert property ($onehot0(o_led_drive))
        else $error("more than one led driver on");
    a_led_in_seq: assert property (o_led_drive != 3'h0 |-> o_slot_b_seq_busy)
        else $error("led on outside sequence");
    a_pulse_holds: assert property ($rose(o_led_drive != 3'h0)
        |=> (o_led_drive != 3'h0 && $stable(o_led_drive)) [*8])
        else $error("led pulse too short");
    a_float_off_idle: assert property (i_slot_b_float_enable != FLOAT_ON_CODE
        |=> !o_slot_b_seq_busy && o_led_drive == 3'h0)
        else $error("sequence runs with float off");
    a_result_after_last: assert property (i_sample_valid && i_sample_last
        |=> o_result_valid && o_result_slot == $past(i_sample_slot))
        else $error("result not reported after last sample");
    a_result_cause: assert property (o_result_valid
        |-> $past(i_sample_valid && i_sample_last))
        else $error("result without last sample");
endmodule // fmpm_config_props
bind fmpm_config_top fmpm_config_props #(.PULSE_CNT_W(PULSE_CNT_W)) u_props (.i_clk, .i_rstn,
    .i_reg_rd, .i_reg_addr, .o_reg_rdata, .o_reg_rvalid, .i_transimpedance_amp_mode,
    .o_integrator_as_buffer, .i_slot_b_float_enable, .i_slot_b_seq_start,
    .i_slot_b_pulse_count, .o_led_drive, .o_slot_b_seq_busy, .i_sample_valid,
    .i_sample_slot, .i_sample_last, .o_result_valid, .o_result_slot);
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the float-mode configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fmpm_pkg::*;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic wr = 1'b0, rd = 1'b0, a_on = 1'b0, transimpedance_amp = 1'b0, start = 1'b0;
    logic sv = 1'b0, ss = 1'b0, sf = 1'b0, sl = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] cnt = 8'h01;
    logic [15:0] wdata = 16'h0000;
    logic [1:0] b_en = 2'h0;
    logic [13:0] smp = 14'h0000;
    logic [15:0] rdata;
    logic [2:0] led;
    logic rvalid, buf_on, busy, res_v, res_s;
    logic [26:0] res;
    int n_mismatch = 0;
    int num_checks = 0;
    always #2 i_clk = ~i_clk;
    fmpm_config_top dut_u (.i_clk, .i_rstn, .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_slot_a_float_on(a_on), .i_slot_b_float_enable(b_en),
        .i_transimpedance_amp_mode(transimpedance_amp), .o_integrator_as_buffer(buf_on),
        .i_slot_b_seq_start(start), .i_slot_b_pulse_count(cnt), .o_led_drive(led),
        .o_slot_b_seq_busy(busy), .i_sample_valid(sv), .i_sample_slot(ss),
        .i_sample_first(sf), .i_sample_last(sl), .i_sample(smp), .o_result_valid(res_v),
        .o_result_slot(res_s), .o_result(res));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic hang(input int k, input int lim);
        if (k >= lim) begin
            n_mismatch++;
            end_of_test();
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
        int k;
        @(posedge i_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge i_clk);
        rd <= 1'b0;
        #1;
        for (k = 0; k < 4 && rvalid !== 1'b1; k++) @(posedge i_clk) #1;
        hang(k, 4);
        check("read data", {16'h0, exp}, {16'h0, rdata});
    endtask
    task automatic reg_case();
        reg_rd(REG_LED_PULSE_ADDR, 16'h0320);
        reg_rd(REG_MATH_ADDR, 16'h0000);
        reg_wr(REG_LED_PULSE_ADDR, 16'hFFFF);
        reg_wr(REG_MATH_ADDR, 16'hFFFF);
        reg_wr(8'h40, 16'hFFFF);
        reg_rd(REG_LED_PULSE_ADDR, 16'hDFFF);
        reg_rd(REG_MATH_ADDR, 16'h0FE6);
        reg_rd(8'h40, 16'h0000);
        $display("register test done");
    endtask
    task automatic buf_case();
        reg_wr(REG_MATH_ADDR, 16'h0080);
        repeat (2) @(posedge i_clk);
        #1 check("buffer off", 32'h0, {31'h0, buf_on});
        @(posedge i_clk);
        transimpedance_amp <= 1'b1;
        repeat (2) @(posedge i_clk);
        #1 check("buffer on", 32'h1, {31'h0, buf_on});
        @(posedge i_clk);
        transimpedance_amp <= 1'b0;
        $display("buffer test done");
    endtask
    task automatic pulse_start(input logic [1:0] en);
        @(posedge i_clk);
        b_en <= en;
        start <= 1'b1;
        @(posedge i_clk);
        start <= 1'b0;
    endtask
    task automatic led_case(input logic [1:0] ch, input logic [2:0] exp);
        int k;
        reg_wr(REG_LED_PULSE_ADDR, {ch, 1'b0, 5'(ch), 8'h01});
        pulse_start(2'h3);
        for (k = 0; k < 400 && led === 3'h0; k++) @(posedge i_clk) #1;
        hang(k, 400);
        check("led delay", 32'(STEP_CYCLES), k);
        check("led choice", {29'h0, exp}, {29'h0, led});
        for (k = 0; k < 1000 && led !== 3'h0; k++) @(posedge i_clk) #1;
        check("led width", 32'(ch) * 250, k);
        for (k = 0; k < 300 && busy !== 1'b0; k++) @(posedge i_clk) #1;
        hang(k, 300);
        $display("led test done");
    endtask
    task automatic led_refuse();
        reg_wr(REG_LED_PULSE_ADDR, 16'h0101);
        pulse_start(2'h1);
        repeat (3) @(posedge i_clk);
        #1 check("busy refused", 32'h0, {31'h0, busy});
        pulse_start(2'h3);
        repeat (400) @(posedge i_clk);
        #1 check("busy running", 32'h1, {31'h0, busy});
        check("no led", 32'h0, {29'h0, led});
        pulse_start(2'h0);
        #1 check("busy aborted", 32'h0, {31'h0, busy});
        $display("refuse test done");
    endtask
    task automatic gap_case();
        int k;
        reg_wr(REG_LED_PULSE_ADDR, 16'h4101);
        cnt <= 8'h02;
        pulse_start(2'h3);
        for (k = 0; k < 400 && led === 3'h0; k++) @(posedge i_clk) #1;
        hang(k, 400);
        for (k = 0; k < 400 && led !== 3'h0; k++) @(posedge i_clk) #1;
        hang(k, 400);
        for (k = 0; k < 400 && led === 3'h0; k++) @(posedge i_clk) #1;
        hang(k, 400);
        check("gap length", 32'(GAP_STEPS) * STEP_CYCLES, k);
        check("gap busy", 32'h1, {31'h0, busy});
        for (k = 0; k < 400 && led !== 3'h0; k++) @(posedge i_clk) #1;
        hang(k, 400);
        check("second width", 32'(STEP_CYCLES), k);
        for (k = 0; k < 300 && busy !== 1'b0; k++) @(posedge i_clk) #1;
        hang(k, 300);
        $display("gap test done");
    endtask
    task automatic math_case(input logic slot, input logic [1:0] c1, c2, input logic fl);
        int e, i;
        logic [1:0] c;
        logic [13:0] v;
        e = 0;
        reg_wr(REG_MATH_ADDR, slot ? {4'h0, c2, 3'h0, c1, 5'h00} : {6'h00, c2, 5'h00, c1, 1'b0});
        a_on <= fl && !slot;
        b_en <= (fl && slot) ? 2'h3 : 2'h0;
        for (i = 0; i < 8; i++) begin
            v = 14'(i * 613 + 100);
            c = (i % 4 < 2) ? c1 : c2;
            e = (fl && c[1 - i % 2]) ? e - int'(v) : e + int'(v);
            @(posedge i_clk);
            sv <= 1'b1;
            ss <= slot;
            sf <= (i == 0);
            sl <= (i == 7);
            smp <= v;
        end
        @(posedge i_clk);
        sv <= 1'b0;
        #1;
        check("result valid", 32'h1, {31'h0, res_v});
        check("result slot", {31'h0, slot}, {31'h0, res_s});
        check("result", {5'h0, 27'(e)}, {5'h0, res});
        $display("math test done");
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        reg_case();
        buf_case();
        for (int c = 1; c < 4; c++) led_case(2'(c), 3'(1 << (c - 1)));
        led_refuse();
        gap_case();
        for (int c = 0; c < 4; c++) begin
            math_case(1'b1, 2'(c), 2'(3 - c), 1'b1);
            math_case(1'b0, 2'(c), 2'(c), 1'b1);
        end
        math_case(1'b1, 2'h3, 2'h3, 1'b0);
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
